// [logic/scu_pkg.sv]
/*
  Shared constants for the serial communication unit: register offsets, field positions,
  reset values and the rate generator table.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
`default_nettype none

package scu_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_CTRL_ONE = 5'h04;
  localparam logic [4:0] OFS_CTRL_TWO = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_BAUD = 5'h10;

  // Field positions of serial_ctrl_one.
  localparam int unsigned C1_R8 = 7;
  localparam int unsigned C1_T8 = 6;
  localparam int unsigned C1_LEN9 = 4;
  localparam int unsigned C1_WAKE_ADDR = 3;

  // Field positions of serial_ctrl_two.
  localparam int unsigned C2_TX_IRQ_EN = 7;
  localparam int unsigned C2_TX_COMPLETE_IRQ_EN = 6;
  localparam int unsigned C2_RX_IRQ_EN = 5;
  localparam int unsigned C2_IDLE_IRQ_EN = 4;
  localparam int unsigned C2_TX_EN = 3;
  localparam int unsigned C2_RX_EN = 2;
  localparam int unsigned C2_RX_SLEEP = 1;
  localparam int unsigned C2_SEND_BREAK = 0;

  // Field positions of serial_status_reg.
  localparam int unsigned ST_TX_EMPTY = 7;
  localparam int unsigned ST_TX_COMPLETE = 6;
  localparam int unsigned ST_RX_FULL = 5;
  localparam int unsigned ST_IDLE = 4;
  localparam int unsigned ST_OVERRUN = 3;
  localparam int unsigned ST_NOISE = 2;
  localparam int unsigned ST_FRAMING = 1;

  // Reset values.
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [4:0] RST_BAUD = 5'h00;

  // Samples per bit, frame lengths in bits, AXI responses.
  localparam int unsigned RT_PER_BIT_DEF = 16;
  localparam logic [3:0] FRAME_BITS_8 = 4'h0A;
  localparam logic [3:0] FRAME_BITS_9 = 4'h0B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Four prescalers times eight binary dividers give the 32 selectable rates.
  function automatic logic [10:0] scu_rate_div(input logic [4:0] sel);
    logic [10:0] pre;
    pre = 11'h001;
    case (sel[4:3])
      2'h0: pre = 11'h001;
      2'h1: pre = 11'h003;
      2'h2: pre = 11'h004;
      default: pre = 11'h00D;
    endcase
    return pre << sel[2:0];
  endfunction : scu_rate_div

endpackage : scu_pkg

`default_nettype wire

// [logic/scu_rx_if.sv]
/*
  Link between the register side of the serial unit and its receiver.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface scu_rx_if;
  logic rt_tick;
  logic enable;
  logic nine_bit;
  logic done;
  logic [8:0] data;
  logic noise;
  logic frame_err;
  logic idle;

  modport ctrl (output rt_tick, output enable, output nine_bit,
                input done, input data, input noise, input frame_err, input idle);
  modport rx (input rt_tick, input enable, input nine_bit,
              output done, output data, output noise, output frame_err, output idle);
endinterface : scu_rx_if

`default_nettype wire

// [logic/scu_rx.sv]
/*
  Receiver of the serial unit: 16x oversampling, majority vote, framing, break and idle detection.
  Assumes rx_serial_in is synchronous to aclk and rt_tick is a one-cycle pulse at 16x the bit rate.
*/
`default_nettype none

module scu_rx
  import scu_pkg::*;
#(
  parameter int unsigned RT_PER_BIT = RT_PER_BIT_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_serial_in,
  scu_rx_if.rx lnk
);

  localparam int unsigned CW = $clog2(RT_PER_BIT + 1);
  localparam int unsigned IW = $clog2(RT_PER_BIT * 11 + 1);
  localparam logic [CW-1:0] RT_LAST = CW'(RT_PER_BIT);

  initial begin
    if (RT_PER_BIT < 12) $error("scu_rx: RT_PER_BIT must be at least 12");
  end

  typedef enum logic [1:0] {SCU_RX_IDLE, SCU_RX_BITS, SCU_RX_WAIT_HIGH} scu_rx_state_t;

  scu_rx_state_t state_q;
  logic [CW-1:0] rt_cnt_q;
  logic [3:0] bit_idx_q;
  logic [2:0] samp_q;
  logic [8:0] shift_q;
  logic noise_acc_q;
  logic [IW-1:0] idle_cnt_q;
  logic vote;
  logic [3:0] last_bit;
  logic [IW-1:0] idle_target;

  // Majority of the three samples decides the bit.
  assign vote = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) | (samp_q[0] & samp_q[2]);
  assign last_bit = lnk.nine_bit ? 4'h9 : 4'h8;
  assign idle_target = IW'(RT_PER_BIT) * (lnk.nine_bit ? IW'(11) : IW'(10));

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; a disabled receiver forgets any partial character.
  always_ff @(posedge aclk) begin
    lnk.done <= 1'b0;
    if (!aresetn || !lnk.enable) begin
      state_q <= SCU_RX_IDLE;
      rt_cnt_q <= '0;
      bit_idx_q <= 4'h0;
      samp_q <= 3'h0;
      shift_q <= 9'h000;
      noise_acc_q <= 1'b0;
      lnk.data <= 9'h000;
      lnk.noise <= 1'b0;
      lnk.frame_err <= 1'b0;
    end else if (lnk.rt_tick) begin
      case (state_q)
        SCU_RX_IDLE: begin
          if (!rx_serial_in) begin
            state_q <= SCU_RX_BITS;
            rt_cnt_q <= CW'(2);
            bit_idx_q <= 4'h0;
            noise_acc_q <= 1'b0;
          end
        end
        SCU_RX_BITS: begin
          rt_cnt_q <= (rt_cnt_q == RT_LAST) ? CW'(1) : rt_cnt_q + CW'(1);
          if (rt_cnt_q >= CW'(8) && rt_cnt_q <= CW'(10)) begin
            samp_q <= {samp_q[1:0], rx_serial_in};
          end
          if (rt_cnt_q == RT_LAST) begin
            bit_idx_q <= bit_idx_q + 4'h1;
            noise_acc_q <= noise_acc_q | ~(&samp_q | ~|samp_q);
            if (bit_idx_q == 4'h0 && vote) begin
              state_q <= SCU_RX_IDLE; // A start that votes high was a glitch.
            end else if (bit_idx_q == last_bit + 4'h1) begin
              lnk.done <= 1'b1;
              lnk.data <= lnk.nine_bit ? shift_q : {1'b0, shift_q[8:1]};
              lnk.noise <= noise_acc_q | ~(&samp_q | ~|samp_q);
              lnk.frame_err <= ~vote;
              // A break needs a real high level before the next start is accepted.
              state_q <= (!vote && shift_q == 9'h000) ? SCU_RX_WAIT_HIGH : SCU_RX_IDLE;
            end else if (bit_idx_q != 4'h0) begin
              shift_q <= {vote, shift_q[8:1]};
            end
          end
        end
        SCU_RX_WAIT_HIGH: begin
          if (rx_serial_in) state_q <= SCU_RX_IDLE;
        end
        default: state_q <= SCU_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle detector: one pulse per stretch of continuous high lasting a whole frame.
  always_ff @(posedge aclk) begin
    lnk.idle <= 1'b0;
    if (!aresetn || !lnk.enable) begin
      idle_cnt_q <= '0;
    end else if (lnk.rt_tick) begin
      if (!rx_serial_in) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q < idle_target) begin
        idle_cnt_q <= idle_cnt_q + IW'(1);
        lnk.idle <= (idle_cnt_q == idle_target - IW'(1));
      end
    end
  end

endmodule : scu_rx

`default_nettype wire

// [logic/scu_serial_comm_unit.sv]
/*
  Serial communication unit: AXI4-Lite register slave, shared rate generator, transmitter,
  flag and interrupt-request logic; the receiver is the scu_rx instance.
  Assumes all inputs are synchronous to aclk; tx_serial_out is released when tx_serial_oe_n is high.
*/
// Behaviour
// - Transmitter and receiver independent, one rate generator.
// - Thirty-two selectable bit rates for both directions.
// - Eight or nine data bits selectable.
// - Wakeup method select; sleep bit enters wakeup.
// - Data address: write transmit, read receive.
// - Data write starts transmission on bit clock.
// - Transfer to shifter sets empty flag, interrupt.
// - Least significant bit first both ways.
// - Frame done, nothing queued: complete flag, interrupt.
// - Disabled transmitter finished sending sets complete.
// - Disabling mid-character finishes it before release; here the line is released one clock after its stop bit starts.
// - Received character fills buffer, sets full flag.
// - Overrun, noise, framing errors reported.
// - Idle flag with enable raises interrupt.
// - Idle flag needs a character received first.
// - Low start, data, high stop; idle high.
// - Break is low for a whole frame.
// - Separate transmit and receive enable bits.
// - Sleep blocks receiver flags; wakeup clears sleep.
// - Idle is ten or eleven high bit times.
// - Sixteen samples per bit, majority of three.
// - Address mark wakes on most significant one.
`default_nettype none

module scu_serial_comm_unit
  import scu_pkg::*;
#(
  parameter int unsigned ADDR_W = 5,
  parameter int unsigned RT_PER_BIT = RT_PER_BIT_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_serial_in,
  output logic tx_serial_out,
  output logic tx_serial_oe_n,
  output logic irq_req
);

  localparam int unsigned PW = $clog2(RT_PER_BIT);

  initial begin
    if (ADDR_W < 5) $error("scu_serial_comm_unit: ADDR_W must be at least 5");
    if (RT_PER_BIT < 12) $error("scu_serial_comm_unit: RT_PER_BIT must be at least 12");
  end

  // Word decode used by both the write and the read path.
  function automatic logic [2:0] scu_decode(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    if (addr[1:0] == 2'h0 && ADDR_W'(addr >> 5) == '0) begin
      case (addr[4:0])
        OFS_DATA: idx = 3'h0;
        OFS_CTRL_ONE: idx = 3'h1;
        OFS_CTRL_TWO: idx = 3'h2;
        OFS_STATUS: idx = 3'h3;
        OFS_BAUD: idx = 3'h4;
        default: idx = 3'h7;
      endcase
    end
    return idx;
  endfunction : scu_decode

  scu_rx_if rxl ();

  // Bus slave state.
  logic aw_have_q, w_have_q;
  logic [2:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_go, rd_go;
  logic [2:0] ar_idx;
  // Registers.
  logic [7:0] tx_hold_q, rx_buf_q, ctrl_two_q;
  logic t8_q, r8_q, nine_q, wake_addr_q;
  logic [4:0] baud_q;
  logic tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q;
  logic status_seen_q, idle_armed_q;
  logic data_wr, data_rd, status_rd;
  // Rate generator and transmitter.
  logic [10:0] div_cnt_q;
  logic rt_tick_q;
  logic [PW-1:0] phase_q;
  logic bit_tick;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic tx_active_q, te_prev_q, preamble_pend_q;
  logic tx_en, rx_en, sleep, send_break_ctl;
  logic [3:0] frame_bits;
  // Receiver events after sleep gating.
  logic addr_wake, rx_take, rx_idle_wake;

  assign tx_en = ctrl_two_q[C2_TX_EN];
  assign rx_en = ctrl_two_q[C2_RX_EN];
  assign sleep = ctrl_two_q[C2_RX_SLEEP];
  assign send_break_ctl = ctrl_two_q[C2_SEND_BREAK];
  assign frame_bits = nine_q ? FRAME_BITS_9 : FRAME_BITS_8;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data are taken in either order.
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 3'h7;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= scu_decode(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx_q == 3'h7) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: one cycle from address to data, no wait states.
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign ar_idx = scu_decode(s_axi_araddr);
  assign data_wr = wr_go && wlane_q && aw_idx_q == 3'h0;
  assign data_rd = rd_go && ar_idx == 3'h0;
  assign status_rd = rd_go && ar_idx == 3'h3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (ar_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
      case (ar_idx)
        3'h0: s_axi_rdata <= {24'h00_0000, rx_buf_q};
        3'h1: s_axi_rdata <= {24'h00_0000, r8_q, t8_q, 1'b0, nine_q, wake_addr_q, 3'h0};
        3'h2: s_axi_rdata <= {24'h00_0000, ctrl_two_q};
        3'h3: s_axi_rdata <= {24'h00_0000, tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, 1'b0};
        3'h4: s_axi_rdata <= {27'h000_0000, baud_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; hardware wakeup clears the sleep bit and wins over a write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_two_q <= RST_CTRL_TWO;
      baud_q <= RST_BAUD;
      nine_q <= 1'b0;
      wake_addr_q <= 1'b0;
      t8_q <= 1'b0;
      tx_hold_q <= 8'h00;
    end else begin
      if (wr_go && wlane_q) begin
        case (aw_idx_q)
          3'h0: tx_hold_q <= wbyte_q;
          3'h1: begin
            t8_q <= wbyte_q[C1_T8];
            nine_q <= wbyte_q[C1_LEN9];
            wake_addr_q <= wbyte_q[C1_WAKE_ADDR];
          end
          3'h2: ctrl_two_q <= wbyte_q;
          3'h4: baud_q <= wbyte_q[4:0];
          default: ;
        endcase
      end
      if (addr_wake || rx_idle_wake) ctrl_two_q[C2_RX_SLEEP] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared rate generator: the sample tick feeds the receiver, its sixteenth feeds the transmitter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 11'h000;
      rt_tick_q <= 1'b0;
      phase_q <= '0;
    end else begin
      rt_tick_q <= 1'b0;
      if (div_cnt_q >= scu_rate_div(baud_q) - 11'h001) begin
        div_cnt_q <= 11'h000;
        rt_tick_q <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 11'h001;
      end
      if (rt_tick_q) phase_q <= (phase_q == PW'(RT_PER_BIT - 1)) ? '0 : phase_q + PW'(1);
    end
  end

  assign bit_tick = rt_tick_q && phase_q == PW'(RT_PER_BIT - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter. A frame always runs to its end, even if the enable drops meanwhile,
  // but with the enable low the output is released one clock after the frame's last bit starts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_active_q <= 1'b0;
      te_prev_q <= 1'b0;
      preamble_pend_q <= 1'b0;
      tx_serial_out <= 1'b1;
      tx_serial_oe_n <= 1'b1;
    end else begin
      te_prev_q <= tx_en;
      if (tx_en && !te_prev_q) preamble_pend_q <= 1'b1;
      tx_serial_oe_n <= !(tx_en || tx_left_q != 4'h0);
      if (bit_tick) begin
        if (tx_left_q != 4'h0) begin
          tx_serial_out <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end else if (tx_en && preamble_pend_q) begin
          preamble_pend_q <= 1'b0;
          tx_serial_out <= 1'b1;
          tx_shift_q <= 11'h7FF;
          tx_left_q <= frame_bits - 4'h1;
          tx_active_q <= 1'b1;
        end else if (tx_en && !tx_buffer_empty_flag_q) begin
          tx_serial_out <= 1'b0;
          tx_shift_q <= nine_q ? {1'b1, 1'b1, t8_q, tx_hold_q} : {2'b11, 1'b1, tx_hold_q};
          tx_left_q <= frame_bits - 4'h1;
          tx_active_q <= 1'b1;
        end else if (tx_en && send_break_ctl) begin
          tx_serial_out <= 1'b0;
          tx_shift_q <= 11'h000;
          tx_left_q <= frame_bits - 4'h1;
          tx_active_q <= 1'b1;
        end else begin
          tx_serial_out <= 1'b1;
          tx_active_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit flags. Reading status then writing data clears complete; the data write itself
  // fills the holding register. A hardware set in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tc_q <= 1'b1;
    end else begin
      if (data_wr) tx_buffer_empty_flag_q <= 1'b0;
      if (data_wr && status_seen_q) tc_q <= 1'b0;
      if (bit_tick && tx_left_q == 4'h0 && tx_en && !preamble_pend_q && !tx_buffer_empty_flag_q) begin
        tx_buffer_empty_flag_q <= 1'b1;
      end
      if (bit_tick && tx_left_q == 4'h0 && tx_active_q &&
          !(tx_en && (preamble_pend_q || !tx_buffer_empty_flag_q || send_break_ctl))) begin
        tc_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver link and wakeup. In address mode the waking character itself is accepted.
  assign rxl.rt_tick = rt_tick_q;
  assign rxl.enable = rx_en;
  assign rxl.nine_bit = nine_q;
  assign addr_wake = rxl.done && sleep && wake_addr_q &&
                     (nine_q ? rxl.data[8] : rxl.data[7]);
  assign rx_idle_wake = rxl.idle && sleep && !wake_addr_q;
  assign rx_take = rxl.done && (!sleep || addr_wake);

  scu_rx #(
    .RT_PER_BIT(RT_PER_BIT)
  ) u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_serial_in(rx_serial_in),
    .lnk(rxl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flags. Reading status then reading data clears them; an overrun
  // keeps the older character so software sees what it missed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= 8'h00;
      r8_q <= 1'b0;
      rx_buffer_full_flag_q <= 1'b0;
      idle_q <= 1'b0;
      or_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      idle_armed_q <= 1'b0;
      status_seen_q <= 1'b0;
    end else begin
      if (status_rd) status_seen_q <= 1'b1;
      else if (data_rd || data_wr) status_seen_q <= 1'b0;
      if (data_rd && status_seen_q) begin
        rx_buffer_full_flag_q <= 1'b0;
        idle_q <= 1'b0;
        or_q <= 1'b0;
        nf_q <= 1'b0;
        fe_q <= 1'b0;
      end
      if (rx_take) begin
        idle_armed_q <= 1'b1;
        if (rx_buffer_full_flag_q && !(data_rd && status_seen_q)) begin
          or_q <= 1'b1;
        end else begin
          rx_buf_q <= rxl.data[7:0];
          r8_q <= rxl.data[8];
          rx_buffer_full_flag_q <= 1'b1;
        end
        if (rxl.noise) nf_q <= 1'b1;
        if (rxl.frame_err) fe_q <= 1'b1;
      end
      if (rxl.idle && !sleep && idle_armed_q) begin
        idle_q <= 1'b1;
        idle_armed_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request: a level while any enabled flag stands.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= (ctrl_two_q[C2_TX_IRQ_EN] && tx_buffer_empty_flag_q) ||
                 (ctrl_two_q[C2_TX_COMPLETE_IRQ_EN] && tc_q) ||
                 (ctrl_two_q[C2_RX_IRQ_EN] && (rx_buffer_full_flag_q || or_q)) ||
                 (ctrl_two_q[C2_IDLE_IRQ_EN] && idle_q);
    end
  end

endmodule : scu_serial_comm_unit

`default_nettype wire

// [sim/scu_serial_comm_unit_monitor.sv]
/* Checker for the serial unit's ports: bus answers and the shape of the transmit line.
   Assumes it is bound to scu_serial_comm_unit and that aclk is the only clock. */
`default_nettype none
module scu_serial_comm_unit_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic tx_serial_out,
  input wire logic tx_serial_oe_n,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////
  // A write is taken when both channels meet; any start bit lasts at least half a bit.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_start_low;
    !tx_serial_out [*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> tx_serial_out && tx_serial_oe_n && !irq_req)
    else $error("outputs not quiet after reset");
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_idle_high: assert property (tx_serial_oe_n |-> tx_serial_out)
    else $error("released line not high");
  a_start_bit: assert property ($fell(tx_serial_out) |-> !tx_serial_oe_n ##0 s_start_low)
    else $error("start bit too short");
endmodule : scu_serial_comm_unit_monitor
`default_nettype wire

// [sim/scu_remote_station.sv]
/* Remote station model: sends frames into the unit and decodes the unit's output line.
   Assumes sixteen clocks per bit and a line that rests high. */
`default_nettype none
module scu_remote_station (
  input wire logic aclk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial line_out = 1'b1;
  ////////////////////////////////
  // Start low, data lowest bit first, chosen stop level, then one idle bit high.
  task automatic send(input logic [7:0] v, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (16) @(posedge aclk);
    end
  endtask : send
  // Samples mid-bit; a bad stop is stored inverted so that it never matches.
  initial begin : decode
    logic [7:0] v;
    forever begin
      @(negedge line_in);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge aclk);
        v[i] = line_in;
      end
      repeat (16) @(posedge aclk);
      got.push_back(line_in ? v : ~v);
    end
  end
endmodule : scu_remote_station
`default_nettype wire

// [sim/test_scu_serial_comm_unit.sv]
/* Self-checking bench for the serial unit: bus tasks, a remote station and a queue model.
   Assumes the fastest rate setting, sixteen clocks per bit. */
`default_nettype none
module test_scu_serial_comm_unit
  import scu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, iq;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0000_0000, d;
  logic [1:0] r;
  logic [7:0] txq[$];
  wire logic awr, wrr, bv, arr, rv, tx, oe_n, irq, rxd;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdat;
  int errors = 0;
  int checks = 0;
  scu_serial_comm_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .rx_serial_in(rxd), .tx_serial_out(tx), .tx_serial_oe_n(oe_n), .irq_req(irq));
  scu_remote_station rs (.aclk(aclk), .line_in(tx), .line_out(rxd));
  initial forever #25 aclk = ~aclk;
  ////////////////////////////////
  // Verdict and compare helpers; a wait that runs out ends the run as a failure.
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic hold(input bit bad);
    if (bad) begin
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask : hold
  // Bus cycles: valid rises after an edge and drops after the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    int n;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    @(negedge aclk);
    for (n = 0; n < 200 && !(awr && wrr); n++) @(negedge aclk);
    hold(n >= 200);
    @(posedge aclk);
    awv <= 1'b0;
    wv <= 1'b0;
    @(negedge aclk);
    for (n = 0; n < 200 && !bv; n++) @(negedge aclk);
    hold(n >= 200);
    cmp(32'(br), 32'(RESP_OKAY));
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    @(negedge aclk);
    for (n = 0; n < 200 && !arr; n++) @(negedge aclk);
    hold(n >= 200);
    @(posedge aclk);
    arv <= 1'b0;
    @(negedge aclk);
    for (n = 0; n < 200 && !rv; n++) @(negedge aclk);
    hold(n >= 200);
    d = rdat;
    r = rr;
    iq = irq;
    @(posedge aclk);
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    cmp(d & {24'h00_0000, m}, {24'h00_0000, e});
  endtask : rdc
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(OFS_STATUS);
      if (d[b] === 1'b1) break;
    end
    hold(n >= 400);
  endtask : poll
  ////////////////////////////////
  // Main sequence; expected bytes live in the queue model.
  initial begin
    logic [7:0] b;
    int n;
    n = $urandom(88);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (200) @(posedge aclk);
    rdc(OFS_STATUS, 8'hFE, 8'hC0);
    rdc(OFS_CTRL_TWO, 8'hFF, RST_CTRL_TWO);
    rd(5'h14);
    cmp(32'(r), 32'(RESP_SLVERR));
    $display("test reset done");
    wr(OFS_CTRL_TWO, 32'h0000_002C);
    b = 8'($urandom);
    fork
      rs.send(b, 1'b1);
      for (int i = 0; i < 2; i++) begin
        poll(ST_TX_EMPTY);
        txq.push_back(8'($urandom));
        wr(OFS_DATA, {24'h00_0000, txq[i]});
      end
    join
    poll(ST_TX_COMPLETE);
    cmp(32'(iq), 32'h0000_0001);
    rdc(OFS_STATUS, 8'h3E, 8'h30);
    rdc(OFS_DATA, 8'hFF, b);
    rd(OFS_CTRL_TWO);
    cmp(32'(iq), 32'h0000_0000);
    foreach (txq[i]) cmp(32'(rs.got[i]), 32'(txq[i]));
    $display("test duplex done");
    txq.push_back(8'($urandom));
    rd(OFS_STATUS);
    wr(OFS_DATA, {24'h00_0000, txq[2]});
    for (n = 0; n < 400 && tx; n++) @(negedge aclk);
    hold(n >= 400);
    @(posedge aclk);
    wr(OFS_CTRL_TWO, 32'h0000_0024);
    poll(ST_TX_COMPLETE);
    cmp(32'(rs.got.size()), 32'd3);
    cmp(32'(rs.got[2]), 32'(txq[2]));
    $display("test disable done");
    rs.send(8'hA5, 1'b1);
    rs.send(~b, 1'b1);
    rdc(OFS_STATUS, 8'h2E, 8'h28);
    rdc(OFS_DATA, 8'hFF, 8'hA5);
    rs.send(b, 1'b0);
    rdc(OFS_STATUS, 8'h22, 8'h22);
    $display("test faults done");
    end_of_test();
  end
endmodule : test_scu_serial_comm_unit
bind scu_serial_comm_unit scu_serial_comm_unit_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .tx_serial_out(tx_serial_out), .tx_serial_oe_n(tx_serial_oe_n), .irq_req(irq_req));
`default_nettype wire
